/* File: adcsq_pkg.sv */
// Summary of operation
// - reference from supply at 0, pin at 1
// - divider codes 000-110 divide 1..64
// - enable bit n makes pin n analog
// - start high then low begins conversion
// - start held high resets converter, busy high
// - busy clears when conversion finishes
// - end of conversion sets request flag, interrupt
// - conversion lasts sixteen converter clock periods
// - converter powered only while power-off is 0
// - analog pin overrides direction, functions, pull-high
package adcsq_pkg;
    // =========================================
    // register map
    localparam logic [1:0] ADCSQ_ADDR_CTRL0 = 2'h0;
    localparam logic [1:0] ADCSQ_ADDR_CTRL1 = 2'h1;
    localparam logic [1:0] ADCSQ_ADDR_PINEN = 2'h2;
    localparam logic [1:0] ADCSQ_ADDR_RESLO = 2'h3;
    localparam logic [1:0] ADCSQ_ADDR_RESHI = 2'h3;
    // adc_control_0 fields
    localparam int ADCSQ_C0_START = 7;
    localparam int ADCSQ_C0_BUSY = 6;
    localparam int ADCSQ_C0_OFF = 5;
    localparam int ADCSQ_C0_IRQF = 4;
    localparam int ADCSQ_C0_IEN = 3;
    localparam int ADCSQ_C0_RSEL = 2;
    // adc_control_1 fields
    localparam int ADCSQ_C1_REF = 4;
    localparam logic [7:0] ADCSQ_C1_MASK = 8'h17;
    localparam logic [7:0] ADCSQ_C0_RST = 8'h20;
    localparam logic [7:0] ADCSQ_C1_RST = 8'h00;
    localparam logic [3:0] ADCSQ_PINEN_RST = 4'hf;
    // timing
    localparam logic [4:0] ADCSQ_CONV_TICKS = 5'h10;
    localparam logic [2:0] ADCSQ_DIV_UNDEF = 3'h7;
    localparam int ADCSQ_MIN_CONVERTER_CLOCK_PERIOD_NS = 500;
    localparam int ADCSQ_CLK_NS = 4;
    localparam int ADCSQ_MIN_CONVERTER_CLOCK_PERIOD_CYC = (ADCSQ_MIN_CONVERTER_CLOCK_PERIOD_NS + ADCSQ_CLK_NS - 1) / ADCSQ_CLK_NS;

    typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_RESET, ADCSQ_CONV} adcsq_state_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adcsq_bus_t;

    typedef struct packed {
        logic [3:0] analog_en;
        logic [3:0] pull_dis;
        logic [3:0] dir_override;
        logic ref_ext;
        logic conv_power;
        logic conv_reset;
        logic sample;
    } adcsq_ana_t;
endpackage : adcsq_pkg

/* File: adcsq_clkdiv.sv */
`timescale 1ns/1ns
module adcsq_clkdiv
    import adcsq_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // control
    input wire logic [2:0] sel_i,
    input wire logic run_i,
    // tick out
    output logic tick_o
);
    typedef struct packed {
        logic [5:0] cnt;
    } adcsq_div_t;

    adcsq_div_t st;
    adcsq_div_t next_st;
    logic [5:0] limit;

    // =========================================
    // divide by 2**sel; code 111 stops the tick
    always_comb begin
        limit = 6'(({6'h0, 1'b1} << sel_i) - 7'h1);
        next_st = st;
        tick_o = 1'b0;
        if (!run_i || sel_i == ADCSQ_DIV_UNDEF) begin
            next_st.cnt = 6'h0;
        end else if (st.cnt >= limit) begin
            next_st.cnt = 6'h0;
            tick_o = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 6'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    a_div_one: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        run_i && sel_i == 3'h0 |-> tick_o) else $error("divide by one missed tick");
    a_div_undef: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        sel_i == ADCSQ_DIV_UNDEF |-> !tick_o) else $error("tick on undefined code");
endmodule : adcsq_clkdiv

/* File: adcsq_ctrl.sv */
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module adcsq_ctrl
    import adcsq_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire adcsq_bus_t bus_i,
    output logic [7:0] rdata_o,
    // converter core
    input wire logic [11:0] conv_result_i,
    output adcsq_ana_t ana_o,
    // interrupt
    output logic irq_o
);
    typedef struct packed {
        adcsq_state_t state;
        logic start;
        logic busy;
        logic off;
        logic irqf;
        logic ien;
        logic rsel;
        logic [7:0] ctrl1;
        logic [3:0] pinen;
        logic [4:0] ticks;
        logic [11:0] result;
        logic [7:0] rdata;
        logic irq;
    } adcsq_st_t;

    adcsq_st_t st;
    adcsq_st_t next_st;
    logic tick;
    logic done;

    adcsq_clkdiv u_div (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .sel_i(st.ctrl1[2:0]),
        .run_i(st.state == ADCSQ_CONV),
        .tick_o(tick)
    );

    // =========================================
    // next state
    always_comb begin
        next_st = st;
        done = 1'b0;
        if (bus_i.wr) begin
            case (bus_i.addr)
                ADCSQ_ADDR_CTRL0: begin
                    next_st.start = bus_i.wdata[ADCSQ_C0_START];
                    next_st.off = bus_i.wdata[ADCSQ_C0_OFF];
                    next_st.ien = bus_i.wdata[ADCSQ_C0_IEN];
                    next_st.rsel = bus_i.wdata[ADCSQ_C0_RSEL];
                    // software may clear the request flag; writing 1 does nothing
                    if (!bus_i.wdata[ADCSQ_C0_IRQF]) begin
                        next_st.irqf = 1'b0;
                    end
                end
                ADCSQ_ADDR_CTRL1: begin
                    next_st.ctrl1 = bus_i.wdata & ADCSQ_C1_MASK;
                end
                ADCSQ_ADDR_PINEN: begin
                    next_st.pinen = bus_i.wdata[3:0];
                end
                default: begin
                end
            endcase
        end
        case (st.state)
            ADCSQ_IDLE, ADCSQ_CONV: begin
                if (next_st.start && !st.start) begin
                    next_st.state = ADCSQ_RESET;
                    next_st.busy = 1'b1;
                end else if (st.state == ADCSQ_CONV && tick) begin
                    next_st.ticks = st.ticks + 5'h1;
                    if (st.ticks == ADCSQ_CONV_TICKS - 5'h1) begin
                        done = 1'b1;
                        next_st.state = ADCSQ_IDLE;
                        next_st.busy = 1'b0;
                        next_st.result = conv_result_i;
                        next_st.irqf = 1'b1;
                    end
                end
            end
            ADCSQ_RESET: begin
                next_st.busy = 1'b1;
                next_st.ticks = 5'h0;
                if (!next_st.start) begin
                    next_st.state = ADCSQ_CONV;
                end
            end
            default: begin
                next_st.state = ADCSQ_IDLE;
            end
        endcase
        next_st.irq = done && st.ien;
        next_st.rdata = 8'h0;
        if (bus_i.rd) begin
            case (bus_i.addr)
                ADCSQ_ADDR_CTRL0: next_st.rdata = {st.start, st.busy, st.off, st.irqf,
                                                   st.ien, st.rsel, 2'h0};
                ADCSQ_ADDR_CTRL1: next_st.rdata = st.ctrl1;
                ADCSQ_ADDR_PINEN: next_st.rdata = {4'h0, st.pinen};
                default: next_st.rdata = st.rsel ? {4'h0, st.result[11:8]}
                                                 : st.result[7:0];
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
            st.state <= ADCSQ_IDLE;
            st.off <= ADCSQ_C0_RST[ADCSQ_C0_OFF];
            st.ctrl1 <= ADCSQ_C1_RST;
            st.pinen <= ADCSQ_PINEN_RST;
        end else begin
            st <= next_st;
        end
    end

    // =========================================
    // outputs
    assign rdata_o = st.rdata;
    assign irq_o = st.irq;
    assign ana_o.analog_en = st.pinen;
    assign ana_o.pull_dis = st.pinen;
    assign ana_o.dir_override = st.pinen;
    assign ana_o.ref_ext = st.ctrl1[ADCSQ_C1_REF];
    assign ana_o.conv_power = !st.off;
    assign ana_o.conv_reset = st.state == ADCSQ_RESET;
    assign ana_o.sample = st.state == ADCSQ_CONV;

    // =========================================
    // checks
    a_busy_in_reset: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        st.state == ADCSQ_RESET |-> st.busy && ana_o.conv_reset)
        else $error("busy low while held in reset");
    a_start_pulse: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        st.state == ADCSQ_RESET && bus_i.wr && bus_i.addr == ADCSQ_ADDR_CTRL0
        && !bus_i.wdata[ADCSQ_C0_START] |=> st.state == ADCSQ_CONV && st.ticks == 5'h0)
        else $error("start fall did not begin conversion");
    a_busy_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        done |=> !st.busy && st.irqf) else $error("busy or flag wrong at end");
    a_irq_enable: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        irq_o |-> $past(st.ien)) else $error("interrupt while disabled");
    a_ref_select: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        bus_i.wr && bus_i.addr == ADCSQ_ADDR_CTRL1 |=>
        ana_o.ref_ext == $past(bus_i.wdata[ADCSQ_C1_REF]))
        else $error("reference not following control");
    a_power_off: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        bus_i.wr && bus_i.addr == ADCSQ_ADDR_CTRL0 |=>
        ana_o.conv_power == !$past(bus_i.wdata[ADCSQ_C0_OFF]))
        else $error("power not following control");
    a_result_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !done |=> st.result == $past(st.result)) else $error("result changed early");
    a_div_one_len: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        st.state == ADCSQ_RESET ##1 st.state == ADCSQ_CONV && st.ctrl1[2:0] == 3'h0
        && !bus_i.wr ##1 !bus_i.wr [*8] ##1 !bus_i.wr [*7] |-> st.busy ##1 !st.busy)
        else $error("conversion length wrong");

    c_conv_done: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) done);
    c_irq: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) irq_o);
    c_restart: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
        st.state == ADCSQ_CONV ##1 st.state == ADCSQ_RESET);
endmodule : adcsq_ctrl

/* File: adc_sequencing_control_test.sv */
`timescale 1ns/1ns
module adc_sequencing_control_test;
    import adcsq_pkg::*;
    // ========================================
    // stimulus and dut
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    adcsq_bus_t bus = '0;
    logic [11:0] result = 12'h000;
    logic [7:0] rdata;
    adcsq_ana_t ana;
    logic irq;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] d;
    adcsq_ctrl dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus),
        .rdata_o(rdata), .conv_result_i(result), .ana_o(ana), .irq_o(irq));
    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end
    // ========================================
    // shared tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // slowest divider code keeps a conversion near a thousand cycles
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge core_clk_i);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge core_clk_i);
        bus.wr <= 1'b0;
        #1;
    endtask : reg_wr
    task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge core_clk_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge core_clk_i);
        bus.rd <= 1'b0;
        #1;
        v = rdata;
    endtask : reg_rd
    // ========================================
    // scenarios
    task automatic reset_values();
        reg_rd(ADCSQ_ADDR_CTRL0, d);
        check("ctrl0 reset", d, 8'h20);
        reg_rd(ADCSQ_ADDR_CTRL1, d);
        check("ctrl1 reset", d, 8'h00);
        reg_rd(ADCSQ_ADDR_PINEN, d);
        check("pinen reset", d, 8'h0f);
        check("analog en", ana.analog_en, 4'hf);
        check("power", ana.conv_power, 1'b0);
        check("ref", ana.ref_ext, 1'b0);
    endtask : reset_values
    task automatic config_regs();
        reg_wr(ADCSQ_ADDR_CTRL1, 8'hff);
        check("ref ext", ana.ref_ext, 1'b1);
        reg_rd(ADCSQ_ADDR_CTRL1, d);
        check("ctrl1 masked", d, 8'h17);
        reg_wr(ADCSQ_ADDR_CTRL1, 8'h00);
        check("ref supply", ana.ref_ext, 1'b0);
        reg_wr(ADCSQ_ADDR_PINEN, 8'ha5);
        reg_rd(ADCSQ_ADDR_PINEN, d);
        check("pinen masked", d, 8'h05);
        check("analog en", ana.analog_en, 4'h5);
        check("pull off", ana.pull_dis, 4'h5);
        check("dir ovr", ana.dir_override, 4'h5);
        reg_wr(ADCSQ_ADDR_CTRL0, 8'h00);
        check("power on", ana.conv_power, 1'b1);
        reg_wr(ADCSQ_ADDR_CTRL0, 8'h20);
        check("power off", ana.conv_power, 1'b0);
        reg_wr(ADCSQ_ADDR_CTRL0, 8'h00);
    endtask : config_regs
    task automatic convert(input logic [2:0] code, input logic ien, input logic [11:0] val);
        int n;
        int dv;
        logic seen_irq;
        n = 0;
        dv = 1 << code;
        seen_irq = 1'b0;
        @(posedge core_clk_i);
        result <= val;
        reg_wr(ADCSQ_ADDR_CTRL1, {5'h00, code});
        reg_wr(ADCSQ_ADDR_CTRL0, {4'h8, ien, 3'h0});
        check("held reset", ana.conv_reset, 1'b1);
        reg_rd(ADCSQ_ADDR_CTRL0, d);
        check("busy held", d[ADCSQ_C0_BUSY], 1'b1);
        check("no sample", ana.sample, 1'b0);
        reg_wr(ADCSQ_ADDR_CTRL0, {4'h0, ien, 3'h0});
        while (ana.sample === 1'b1 && n < 3000) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        check("conv length", 16'(n), 16'(16 * dv));
        // the request pulse stands together with the busy clear
        check("irq", irq, ien);
        repeat (3) begin
            @(posedge core_clk_i);
            #1;
            if (irq !== 1'b0) seen_irq = 1'b1;
        end
        check("irq pulse", seen_irq, 1'b0);
        @(posedge core_clk_i);
        result <= ~val;
        reg_rd(ADCSQ_ADDR_CTRL0, d);
        check("busy clear", d[ADCSQ_C0_BUSY], 1'b0);
        check("irq flag", d[ADCSQ_C0_IRQF], 1'b1);
        reg_rd(ADCSQ_ADDR_RESLO, d);
        check("result lo", d, val[7:0]);
        reg_wr(ADCSQ_ADDR_CTRL0, 8'h04);
        reg_rd(ADCSQ_ADDR_RESHI, d);
        check("result hi", d, {4'h0, val[11:8]});
    endtask : convert
    task automatic restart();
        int n;
        n = 0;
        reg_wr(ADCSQ_ADDR_CTRL1, 8'h02);
        reg_wr(ADCSQ_ADDR_CTRL0, 8'h80);
        reg_wr(ADCSQ_ADDR_CTRL0, 8'h00);
        // a new start edge in mid conversion aborts it
        repeat (20) @(posedge core_clk_i);
        reg_wr(ADCSQ_ADDR_CTRL0, 8'h80);
        check("restart reset", ana.conv_reset, 1'b1);
        check("restart sample", ana.sample, 1'b0);
        reg_wr(ADCSQ_ADDR_CTRL0, 8'h00);
        while (ana.sample === 1'b1 && n < 3000) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        check("restart length", 16'(n), 16'h0040);
        reg_rd(ADCSQ_ADDR_CTRL0, d);
        check("restart busy", d[ADCSQ_C0_BUSY], 1'b0);
    endtask : restart
    // ========================================
    // main sequence
    initial begin
        repeat (20) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        reset_values();
        config_regs();
        convert(3'h0, 1'b1, 12'habc);
        convert(3'h2, 1'b0, 12'h5a3);
        // no code reaches the period floor at this clock; the core here has no accuracy limit
        convert(3'h6, 1'b1, 12'hf01);
        restart();
        report_and_stop();
    end
endmodule : adc_sequencing_control_test
